// file: core/irq_consolidator_map.vh
// Register offsets, widths and reset values of the interrupt consolidator
`ifndef IRQ_CONSOLIDATOR_MAP_VH
`define IRQ_CONSOLIDATOR_MAP_VH
`define MOD_ERR_RECOVERY_STATUS_OFS 12'hA78
`define MOD_ERR_RECOVERY_CLEAR_OFS 12'hA7C
`define UPPER_ERR_RECOVERY_STATUS_OFS 12'hA80
`define UPPER_ERR_RECOVERY_CLEAR_OFS 12'hA84
`define MOD_CRITICAL_STATUS_OFS 12'hA88
`define MOD_CRITICAL_CLEAR_OFS 12'hA8C
`define UPPER_CRITICAL_STATUS_OFS 12'hA90
`define UPPER_CRITICAL_CLEAR_OFS 12'hA94
`define IRQ_STATUS_OFS 12'hA98
`define IRQ_MASK_OFS 12'hA9C
`define MOD_COUNT 6
`define UPPER_COUNT 32
`define STATUS_RESET 32'h0000_0000
`define MASK_RESET 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: core/edge_sticky_bank.v
// Bank of edge-triggered sticky flags with write-one-to-clear
`timescale 1ns/1ps
module edge_sticky_bank #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  input wire ce,
  // Sources and clear strobe
  input wire [WIDTH-1:0] irq_in,
  input wire clr_stb,
  input wire [WIDTH-1:0] clr_bits,
  // Flags
  output wire [WIDTH-1:0] flags
);
  reg [WIDTH-1:0] prev_r;
  reg [WIDTH-1:0] flag_r;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          prev_r[i] <= 1'b0;
          flag_r[i] <= 1'b0;
        end else if (ce) begin
          prev_r[i] <= irq_in[i];
          if (irq_in[i] && !prev_r[i]) begin
            flag_r[i] <= 1'b1;
          end else if (clr_stb && clr_bits[i]) begin
            flag_r[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  assign flags = flag_r;
endmodule

// file: core/tbu_ras_irq_consolidator.v
// Translation-unit error interrupt consolidator with AXI4-Lite registers
// What this block does
// - Each status bit is set on a rising edge of its unit interrupt and holds until software clears it.
// - Writing ones to the module error-recovery clear register clears those status bits.
// - Writing ones to the module critical-error clear register clears those status bits.
// - Writing ones to the upper error-recovery clear register clears those status bits.
// - Writing ones to the upper critical-error clear register clears those status bits.
// - The module critical status holds flags in bits 5..0 while bits 31..6 read zero and ignore writes.
// - Bit n of the module critical status follows the critical interrupt of module n.
// - Bit k of the upper error-recovery status follows the error-recovery interrupt of unit 32+k.
// - Bit k of the upper critical status follows the critical interrupt of unit 32+k.
// - The upper status registers exist only when the system has more than 32 units.
// - Every status register is read-only and resets to zero.
// - A module error-recovery status register captures the six modules' error-recovery interrupts.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "irq_consolidator_map.vh"
module tbu_ras_irq_consolidator #(
  parameter UNIT_COUNT = 64
) (
  // Clock, reset, enable
  input wire clk_sys,
  input wire rst,
  input wire ce,
  // Unit interrupt sources
  input wire [`MOD_COUNT-1:0] mod_err_recovery_irq,
  input wire [`MOD_COUNT-1:0] mod_critical_error_irq,
  input wire [`UPPER_COUNT-1:0] unit_err_recovery_irq,
  input wire [`UPPER_COUNT-1:0] unit_critical_error_irq,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Interrupt
  output wire irq
);
  localparam HAS_UPPER = (UNIT_COUNT > 32) ? 1'b1 : 1'b0;

  // Write channel holding
  reg aw_full_r;
  reg w_full_r;
  reg [11:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  // Read channel
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg [3:0] irq_status_r;
  reg [3:0] irq_mask_r;

  wire wr_fire;
  wire rd_fire;
  wire [9:0] wr_word;
  wire [9:0] rd_word;
  wire clr_full_word;
  wire [31:0] clr_data;

  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready = !w_full_r && !bvalid_r;
  assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
  assign wr_word = aw_addr_r[11:2];
  assign s_axi_arready = !rvalid_r;
  assign rd_fire = s_axi_arvalid && !rvalid_r;
  assign rd_word = s_axi_araddr[11:2];
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  // Byte lanes gate which clear bits take effect
  assign clr_data = w_data_r & {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign clr_full_word = 1'b1;

  // Clear strobes, one per bank
  wire clr_mod_er;
  wire clr_upper_er;
  wire clr_mod_cr;
  wire clr_upper_cr;
  assign clr_mod_er = wr_fire && clr_full_word && (wr_word == `MOD_ERR_RECOVERY_CLEAR_OFS >> 2);
  assign clr_upper_er = wr_fire && HAS_UPPER && (wr_word == `UPPER_ERR_RECOVERY_CLEAR_OFS >> 2);
  assign clr_mod_cr = wr_fire && (wr_word == `MOD_CRITICAL_CLEAR_OFS >> 2);
  assign clr_upper_cr = wr_fire && HAS_UPPER && (wr_word == `UPPER_CRITICAL_CLEAR_OFS >> 2);

  wire [`MOD_COUNT-1:0] mod_er_flags;
  wire [`MOD_COUNT-1:0] mod_cr_flags;
  wire [`UPPER_COUNT-1:0] upper_er_flags;
  wire [`UPPER_COUNT-1:0] upper_cr_flags;
  wire [`UPPER_COUNT-1:0] upper_er_src;
  wire [`UPPER_COUNT-1:0] upper_cr_src;
  assign upper_er_src = HAS_UPPER ? unit_err_recovery_irq : {`UPPER_COUNT{1'b0}};
  assign upper_cr_src = HAS_UPPER ? unit_critical_error_irq : {`UPPER_COUNT{1'b0}};

  edge_sticky_bank #(.WIDTH(`MOD_COUNT)) u_mod_er (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .irq_in(mod_err_recovery_irq),
    .clr_stb(clr_mod_er),
    .clr_bits(clr_data[`MOD_COUNT-1:0]),
    .flags(mod_er_flags)
  );
  edge_sticky_bank #(.WIDTH(`MOD_COUNT)) u_mod_cr (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .irq_in(mod_critical_error_irq),
    .clr_stb(clr_mod_cr),
    .clr_bits(clr_data[`MOD_COUNT-1:0]),
    .flags(mod_cr_flags)
  );
  edge_sticky_bank #(.WIDTH(`UPPER_COUNT)) u_upper_er (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .irq_in(upper_er_src),
    .clr_stb(clr_upper_er),
    .clr_bits(clr_data),
    .flags(upper_er_flags)
  );
  edge_sticky_bank #(.WIDTH(`UPPER_COUNT)) u_upper_cr (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .irq_in(upper_cr_src),
    .clr_stb(clr_upper_cr),
    .clr_bits(clr_data),
    .flags(upper_cr_flags)
  );

  // Bank summary events, one per bank
  wire [3:0] bank_any;
  reg [3:0] bank_prev_r;
  wire [3:0] bank_event;
  assign bank_any = {|upper_cr_flags, |mod_cr_flags, |upper_er_flags, |mod_er_flags};
  assign bank_event = bank_any & ~bank_prev_r;
  assign irq = |(irq_status_r & irq_mask_r);

  // Read mux
  reg [31:0] rd_val;
  reg rd_hit;
  always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (rd_word)
      `MOD_ERR_RECOVERY_STATUS_OFS >> 2: rd_val = {26'h0, mod_er_flags};
      `MOD_CRITICAL_STATUS_OFS >> 2: rd_val = {26'h0, mod_cr_flags};
      `UPPER_ERR_RECOVERY_STATUS_OFS >> 2: rd_val = HAS_UPPER ? upper_er_flags : 32'h0000_0000;
      `UPPER_CRITICAL_STATUS_OFS >> 2: rd_val = HAS_UPPER ? upper_cr_flags : 32'h0000_0000;
      `MOD_ERR_RECOVERY_CLEAR_OFS >> 2: rd_val = 32'h0000_0000;
      `UPPER_ERR_RECOVERY_CLEAR_OFS >> 2: rd_val = 32'h0000_0000;
      `MOD_CRITICAL_CLEAR_OFS >> 2: rd_val = 32'h0000_0000;
      `UPPER_CRITICAL_CLEAR_OFS >> 2: rd_val = 32'h0000_0000;
      `IRQ_STATUS_OFS >> 2: rd_val = {28'h0, irq_status_r};
      `IRQ_MASK_OFS >> 2: rd_val = {28'h0, irq_mask_r};
      default: rd_hit = 1'b0;
    endcase
  end

  wire wr_hit;
  assign wr_hit = (wr_word == `MOD_ERR_RECOVERY_CLEAR_OFS >> 2) || (wr_word == `UPPER_ERR_RECOVERY_CLEAR_OFS >> 2) ||
    (wr_word == `MOD_CRITICAL_CLEAR_OFS >> 2) || (wr_word == `UPPER_CRITICAL_CLEAR_OFS >> 2) ||
    (wr_word == `IRQ_MASK_OFS >> 2) || (wr_word == `MOD_ERR_RECOVERY_STATUS_OFS >> 2) ||
    (wr_word == `UPPER_ERR_RECOVERY_STATUS_OFS >> 2) || (wr_word == `MOD_CRITICAL_STATUS_OFS >> 2) ||
    (wr_word == `UPPER_CRITICAL_STATUS_OFS >> 2) || (wr_word == `IRQ_STATUS_OFS >> 2);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
      irq_status_r <= `MASK_RESET;
      irq_mask_r <= `MASK_RESET;
      bank_prev_r <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        // Unmapped writes answer slave error
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_word == `IRQ_MASK_OFS >> 2) begin
          irq_mask_r <= clr_data[3:0];
        end
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
      bank_prev_r <= bank_any;
      // New event wins over read-to-clear
      if (rd_fire && rd_word == (`IRQ_STATUS_OFS >> 2)) begin
        irq_status_r <= bank_event;
      end else begin
        irq_status_r <= irq_status_r | bank_event;
      end
    end
  end
endmodule

// file: verification/cons_chk_props.sv
// Bus handshake and register read checks for the consolidator
`timescale 1ns/1ps
`include "irq_consolidator_map.vh"
module cons_chk #(
  parameter UNIT_COUNT = 64
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  input wire ce,
  // Write channels
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // Read channels
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  reg [11:0] rd_a_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Address of the read in flight, so data can be judged by target
  always @(posedge clk_sys or posedge rst) begin
    if (rst) rd_a_r <= 12'h000;
    else if (ce && s_axi_arvalid && s_axi_arready) rd_a_r <= s_axi_araddr;
  end
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready while rvalid");
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken in bvalid");
  // Both halves are held for one edge before the response register loads
  a_wr_answer: assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("no write response");
  a_rd_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
  a_clear_reads_zero: assert property (
    s_axi_rvalid && (rd_a_r inside {`MOD_ERR_RECOVERY_CLEAR_OFS, `UPPER_ERR_RECOVERY_CLEAR_OFS,
    `MOD_CRITICAL_CLEAR_OFS, `UPPER_CRITICAL_CLEAR_OFS}) |-> s_axi_rdata == 32'h0) else $error("clear reg read nonzero");
  a_crit_reserved_zero: assert property (
    s_axi_rvalid && rd_a_r == `MOD_CRITICAL_STATUS_OFS |-> s_axi_rdata[31:6] == 26'h0) else $error("reserved bits set");
endmodule
bind tbu_ras_irq_consolidator cons_chk #(.UNIT_COUNT(UNIT_COUNT)) chk_u (.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// file: verification/unit_src_model.sv
// Model of the translation-unit interrupt sources
`timescale 1ns/1ps
module unit_src_model (
  // Clock and command
  input wire clk_sys,
  input wire go,
  input wire [1:0] sel,
  input wire [31:0] pat,
  // Interrupt levels
  output reg [5:0] mod_er_r,
  output reg [31:0] up_er_r,
  output reg [5:0] mod_cr_r,
  output reg [31:0] up_cr_r
);
  initial {mod_er_r, up_er_r, mod_cr_r, up_cr_r} = 76'h0;
  // Levels move only after a clock edge, as unit logic would
  always @(posedge clk_sys) begin
    if (go) begin
      case (sel)
        2'h0: mod_er_r <= pat[5:0];
        2'h1: up_er_r <= pat;
        2'h2: mod_cr_r <= pat[5:0];
        default: up_cr_r <= pat;
      endcase
    end
  end
endmodule

// file: verification/tbu_ras_irq_consolidator_tb.sv
// Self-checking bench for the interrupt consolidator
`timescale 1ns/1ps
`include "irq_consolidator_map.vh"
module tbu_ras_irq_consolidator_tb;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg go = 1'b0;
  reg [1:0] sel = 2'h0;
  reg [31:0] pat = 32'h0;
  reg [11:0] awaddr = 12'h000;
  reg [11:0] araddr = 12'h000;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, u_er, u_cr;
  wire [5:0] m_er, m_cr;
  integer n_errors = 0, checked = 0, b;
  reg [31:0] rd, e;
  always #10 clk_sys = ~clk_sys;
  unit_src_model src_u (.clk_sys(clk_sys), .go(go), .sel(sel), .pat(pat), .mod_er_r(m_er), .up_er_r(u_er),
    .mod_cr_r(m_cr), .up_cr_r(u_cr));
  tbu_ras_irq_consolidator #(.UNIT_COUNT(64)) dut_u (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
    .mod_err_recovery_irq(m_er), .mod_critical_error_irq(m_cr), .unit_err_recovery_irq(u_er),
    .unit_critical_error_irq(u_cr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));
  task end_of_test;
    begin
      $display("Mismatches %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      checked = checked + 1;
      if (g !== x) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask
  // Loop index left at 50 means the slave never answered
  task tmo(input integer i);
    begin
      if (i == 50) begin
        n_errors = n_errors + 1;
        end_of_test;
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d, input [1:0] x);
    integer i;
    begin
      @(posedge clk_sys);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      for (i = 0; i < 50; i = i + 1) begin
        @(posedge clk_sys);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) begin
          bready <= 1'b0;
          chk(bresp, x);
          i = 99;
        end
      end
      tmo(i);
    end
  endtask
  task rdx(input [11:0] a, input [1:0] x, output [31:0] d);
    integer i;
    begin
      @(posedge clk_sys);
      {araddr, arvalid, rready} <= {a, 2'b11};
      for (i = 0; i < 50; i = i + 1) begin
        @(posedge clk_sys);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) begin
          rready <= 1'b0;
          d = rdata;
          chk(rresp, x);
          i = 99;
        end
      end
      tmo(i);
    end
  endtask
  task rd_chk(input [11:0] a, input [31:0] x);
    begin
      rdx(a, `RESP_OKAY, rd);
      chk(rd, x);
    end
  endtask
  // Sources change a cycle after the command; flags land on the next edge
  task src(input integer k, input [31:0] p);
    begin
      @(posedge clk_sys);
      {go, sel, pat} <= {1'b1, k[1:0], p};
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
  function [11:0] st(input integer k);
    st = `MOD_ERR_RECOVERY_STATUS_OFS + 12'(8 * k);
  endfunction
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    for (b = 0; b < 4; b = b + 1) begin
      rd_chk(st(b), `STATUS_RESET);
      rd_chk(st(b) + 12'h4, 32'h0);
    end
    rd_chk(`IRQ_STATUS_OFS, 32'h0);
    for (b = 0; b < 4; b = b + 1) begin
      e = 32'hA5C3_0F96 & (b[0] ? 32'hFFFF_FFFF : 32'h0000_003F);
      src(b, 32'hA5C3_0F96);
      rd_chk(st(b), e);
      chk(irq, b != 0);
      rd_chk(`IRQ_STATUS_OFS, 32'h1 << b);
      @(posedge clk_sys);
      chk(irq, 1'b0);
      wr(st(b) + 12'h4, 32'h0000_0F0F, `RESP_OKAY);
      rd_chk(st(b), e & 32'hFFFF_F0F0);
      rd_chk(st(b) + 12'h4, 32'h0);
      wr(st(b), 32'hFFFF_FFFF, `RESP_OKAY);
      rd_chk(st(b), e & 32'hFFFF_F0F0);
      src(b, 32'h0);
      wr(st(b) + 12'h4, 32'hFFFF_FFFF, `RESP_OKAY);
      rd_chk(st(b), 32'h0);
      wr(`IRQ_MASK_OFS, 32'hF, `RESP_OKAY);
    end
    // Set and clear of one flag land on the same edge: set must survive
    src(0, 32'h1);
    src(0, 32'h0);
    fork
      wr(`MOD_ERR_RECOVERY_CLEAR_OFS, 32'h1, `RESP_OKAY);
      begin
        @(posedge clk_sys);
        {go, sel, pat} <= {1'b1, 2'h0, 32'h1};
        @(posedge clk_sys);
        go <= 1'b0;
      end
    join
    rd_chk(st(0), 32'h1);
    src(0, 32'h0);
    wr(`MOD_ERR_RECOVERY_CLEAR_OFS, 32'hFFFF_FFFF, `RESP_OKAY);
    rd_chk(st(0), 32'h0);
    // Unmapped place: refused, nothing read back
    wr(12'h000, 32'h1, `RESP_SLVERR);
    rdx(12'h000, `RESP_SLVERR, rd);
    chk(rd, 32'h0);
    end_of_test;
  end
endmodule
